// [core/fso_defines.vh]
// constants for the flash status and security register read block
`ifndef FSO_DEFINES_VH
`define FSO_DEFINES_VH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define FSO_OPC_OTP_READ    8'h77
`define FSO_OPC_STAT_READ   8'h05
`define FSO_OPC_STAT_WRITE  8'h01
`define FSO_OPC_STAT2_WRITE 8'h31

// ----------------------------------------------------------------
// frame layout, counted in bytes since chip select fell, and bit positions in a byte
// ----------------------------------------------------------------
`define FSO_BYTE_OPCODE     3'h0
`define FSO_BYTE_ADDR_LAST  3'h3
`define FSO_BYTE_WDATA      3'h1
`define FSO_BYTE_OTP_DATA   3'h6
`define FSO_BIT_LAST        3'h7
`define FSO_BIT_FIRST       3'h0

// ----------------------------------------------------------------
// status byte one fields
// ----------------------------------------------------------------
`define FSO_ST1_LOCK        7
`define FSO_ST1_FAIL        5
`define FSO_ST1_WP          4
`define FSO_ST1_PROTECT     2
`define FSO_ST1_WEL         1
`define FSO_ST1_BUSY        0

// ----------------------------------------------------------------
// status byte two fields
// ----------------------------------------------------------------
`define FSO_ST2_RST_EN      4
`define FSO_ST2_BUSY        0

// ----------------------------------------------------------------
// widths, reset values and steps
// ----------------------------------------------------------------
`define FSO_OTP_AW          7
`define FSO_OTP_ADDR_RST    7'h00
`define FSO_OTP_ADDR_STEP   7'h01
`define FSO_BYTE_RST        8'h00
`define FSO_CNT_RST         3'h0
`define FSO_CNT_STEP        3'h1
// idle levels of cs_n, sck, si, wp_n
`define FSO_PIN_IDLE        4'h9

`endif

// [core/fso_sync.v]
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps

module fso_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // asynchronous in, synchronous out
  input  wire [WIDTH-1:0] async_in,
  input  wire [WIDTH-1:0] rst_val,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;

  always @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= rst_val;
      sync_out <= rst_val;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // fso_sync

// [core/fso_status_otp.v]
// serial flash status register and security register read logic
//
// Summary of operation
// - otp read: opcode 77h, three address bytes, two dummy bytes, then data
// - otp read address steps each byte and wraps from 7Fh to 00h freely
// - chip select rising at any bit ends otp read and floats output
// - status read: opcode 05h, then one status bit per clock
// - status byte one then byte two, msb first, repeating while selected
// - status contents recaptured for every byte sent, never frozen
// - status read is served at any time, even while busy
// - chip select rising at any bit ends status read and floats output
// - status write changes only lock bit 7 and array protect bit 2
// - lock set with protect pin asserted freezes the array protect bit
// - lock bit is cleared at power-up
// - with protect pin asserted lock may only go from zero to one
// - fail flag shows result of last program or erase, refreshed every time one ends without abort
// - fail flag is not set by an aborted program or erase
// - bit 4 reads zero while protect pin asserted, one otherwise
// - array protect bit one protects the whole array from program and erase
// - write latch clear rejects program, erase, otp program and status write
// - write latch is cleared at power-up and reset
// - write latch cleared when write-type operations complete or abort
// - incomplete or unknown opcode leaves a set write latch alone
// - bit 0 reads one while an internal operation runs
// - reserved bits 6 and 3 of byte one read zero
// - byte two: reset command enable in bit 4, busy copy in bit 0
`timescale 1ns/1ps
`include "fso_defines.vh"

module fso_status_otp #(
  // command codes for write enable and write disable
  parameter [7:0] OPC_WR_ENABLE  = 8'h06,
  parameter [7:0] OPC_WR_DISABLE = 8'h04
) (
  // clock and reset
  input  wire                    clk,
  input  wire                    rst_n,
  // serial pins
  input  wire                    cs_n,
  input  wire                    sck,
  input  wire                    si,
  input  wire                    wp_n,
  output reg                     so,
  output reg                     so_oe_n,
  // security register read port
  output reg  [`FSO_OTP_AW-1:0]  otp_addr,
  input  wire [7:0]              otp_data,
  // program and erase engine
  input  wire                    op_busy,
  input  wire                    op_end,
  input  wire                    op_failed,
  input  wire                    op_aborted,
  input  wire                    hold_abort,
  // protection state
  output reg                     array_protect_bit,
  output reg                     write_latch_bit,
  output reg                     write_allowed,
  output reg                     reset_cmd_enable,
  output reg  [7:0]              status_byte_one
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [3:0] pin_sync;
  wire       cs_n_s;
  wire       sck_s;
  wire       si_s;
  wire       wp_n_s;

  fso_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({cs_n, sck, si, wp_n}),
    .rst_val  (`FSO_PIN_IDLE),
    .sync_out (pin_sync)
  );

  assign cs_n_s = pin_sync[3];
  assign sck_s  = pin_sync[2];
  assign si_s   = pin_sync[1];
  assign wp_n_s = pin_sync[0];

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  reg  sck_d_reg;
  reg  cs_n_d_reg;
  wire selected;
  wire sck_rise;
  wire sck_fall;
  wire cs_rise;

  always @(posedge clk) begin
    if (!rst_n) begin
      sck_d_reg  <= 1'b0;
      cs_n_d_reg <= 1'b1;
    end else begin
      sck_d_reg  <= sck_s;
      cs_n_d_reg <= cs_n_s;
    end
  end

  // clock edges count only while selected, so reset levels cannot fake one
  assign selected = !cs_n_s;
  assign sck_rise = selected && sck_s && !sck_d_reg;
  assign sck_fall = selected && !sck_s && sck_d_reg;
  assign cs_rise  = cs_n_s && !cs_n_d_reg;

  // ----------------------------------------------------------------
  // frame counters and input shifter
  // ----------------------------------------------------------------
  reg [2:0] bit_cnt_reg;
  reg [2:0] byte_cnt_reg;
  reg [7:0] shift_in_reg;
  reg [7:0] opcode_reg;
  reg [7:0] wdata_reg;
  reg       wdata_ok_reg;
  wire [7:0] byte_in;
  wire       byte_done;
  wire       opcode_full;
  wire       otp_load;

  assign byte_in     = {shift_in_reg[6:0], si_s};
  assign byte_done   = sck_rise && (bit_cnt_reg == `FSO_BIT_LAST);
  assign opcode_full = (byte_cnt_reg != `FSO_BYTE_OPCODE);

  always @(posedge clk) begin
    if (!rst_n) begin
      bit_cnt_reg  <= `FSO_CNT_RST;
      byte_cnt_reg <= `FSO_CNT_RST;
      shift_in_reg <= `FSO_BYTE_RST;
      opcode_reg   <= `FSO_BYTE_RST;
      wdata_reg    <= `FSO_BYTE_RST;
      wdata_ok_reg <= 1'b0;
      otp_addr     <= `FSO_OTP_ADDR_RST;
    end else if (!selected) begin
      bit_cnt_reg  <= `FSO_CNT_RST;
      byte_cnt_reg <= `FSO_CNT_RST;
      shift_in_reg <= `FSO_BYTE_RST;
      if (!cs_rise) begin
        opcode_reg   <= `FSO_BYTE_RST;
        wdata_ok_reg <= 1'b0;
      end
    end else begin
      if (sck_rise) begin
        shift_in_reg <= byte_in;
        bit_cnt_reg  <= bit_cnt_reg + `FSO_CNT_STEP;
      end
      if (byte_done && byte_cnt_reg != `FSO_BYTE_OTP_DATA) begin
        byte_cnt_reg <= byte_cnt_reg + `FSO_CNT_STEP;
      end
      if (byte_done && byte_cnt_reg == `FSO_BYTE_OPCODE) begin
        opcode_reg <= byte_in;
      end
      // only the first data byte counts, later ones are ignored
      if (byte_done && byte_cnt_reg == `FSO_BYTE_WDATA) begin
        wdata_reg    <= byte_in;
        wdata_ok_reg <= 1'b1;
      end
      if (byte_done && byte_cnt_reg == `FSO_BYTE_ADDR_LAST &&
          opcode_reg == `FSO_OPC_OTP_READ) begin
        otp_addr <= byte_in[`FSO_OTP_AW-1:0];
      end else if (sck_fall && otp_load) begin
        otp_addr <= otp_addr + `FSO_OTP_ADDR_STEP;
      end
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  reg is_stat_read;
  reg is_otp_read;
  reg is_stat_write;
  reg is_stat2_write;
  reg is_wr_enable;
  reg is_wr_disable;

  // a cut opcode leaves the register cleared, which matches no command
  always @* begin
    is_stat_read   = 1'b0;
    is_otp_read    = 1'b0;
    is_stat_write  = 1'b0;
    is_stat2_write = 1'b0;
    is_wr_enable   = 1'b0;
    is_wr_disable  = 1'b0;
    case (opcode_reg)
      `FSO_OPC_STAT_READ: begin
        is_stat_read = 1'b1;
      end
      `FSO_OPC_OTP_READ: begin
        is_otp_read = 1'b1;
      end
      `FSO_OPC_STAT_WRITE: begin
        is_stat_write = 1'b1;
      end
      `FSO_OPC_STAT2_WRITE: begin
        is_stat2_write = 1'b1;
      end
      OPC_WR_ENABLE: begin
        is_wr_enable = 1'b1;
      end
      OPC_WR_DISABLE: begin
        is_wr_disable = 1'b1;
      end
      default: begin
        is_stat_read = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  reg  [7:0] out_sh_reg;
  reg        st_sel_reg;
  reg        lock_reg;
  reg        protect_reg;
  reg        fail_reg;
  reg        wel_reg;
  reg        rst_en_reg;
  wire       at_byte_start;
  wire       stat_load;
  wire [7:0] stat_one_now;
  wire [7:0] stat_two_now;
  wire [7:0] load_byte;

  assign stat_one_now = {lock_reg, 1'b0, fail_reg, wp_n_s,
                         1'b0, protect_reg, wel_reg, op_busy};
  assign stat_two_now = {3'h0, rst_en_reg, 3'h0, op_busy};

  assign at_byte_start = (bit_cnt_reg == `FSO_BIT_FIRST);
  // status read is served regardless of busy
  assign stat_load = at_byte_start && opcode_full &&
                     is_stat_read;
  assign otp_load  = at_byte_start && byte_cnt_reg == `FSO_BYTE_OTP_DATA &&
                     is_otp_read;
  // byte picked at the moment it starts, so each pass is fresh
  assign load_byte = otp_load ? otp_data :
                     (st_sel_reg ? stat_two_now : stat_one_now);

  always @(posedge clk) begin
    if (!rst_n) begin
      so         <= 1'b0;
      so_oe_n    <= 1'b1;
      out_sh_reg <= `FSO_BYTE_RST;
      st_sel_reg <= 1'b0;
    end else if (!selected) begin
      so         <= 1'b0;
      so_oe_n    <= 1'b1;
      st_sel_reg <= 1'b0;
    end else if (sck_fall) begin
      if (stat_load || otp_load) begin
        so         <= load_byte[7];
        out_sh_reg <= {load_byte[6:0], 1'b0};
        so_oe_n    <= 1'b0;
        if (stat_load) begin
          st_sel_reg <= !st_sel_reg;
        end
      end else if (!so_oe_n) begin
        so         <= out_sh_reg[7];
        out_sh_reg <= {out_sh_reg[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // status bits
  // ----------------------------------------------------------------
  wire aligned_end;
  wire stat_wr_end;
  wire stat2_wr_end;
  wire wr_commit;
  wire lock_frozen;

  // write commits only on a byte boundary after a whole data byte
  assign aligned_end  = cs_rise && wdata_ok_reg &&
                        (bit_cnt_reg == `FSO_BIT_FIRST);
  assign stat_wr_end  = cs_rise && is_stat_write;
  assign stat2_wr_end = cs_rise && is_stat2_write;
  assign wr_commit    = aligned_end && wel_reg;
  // lock set and pin asserted: whole write has no effect
  assign lock_frozen  = lock_reg && !wp_n_s;

  always @(posedge clk) begin
    if (!rst_n) begin
      lock_reg    <= 1'b0;
      protect_reg <= 1'b0;
      fail_reg    <= 1'b0;
      wel_reg     <= 1'b0;
      rst_en_reg  <= 1'b0;
    end else begin
      if (stat_wr_end && wr_commit && !lock_frozen) begin
        protect_reg <= wdata_reg[`FSO_ST1_PROTECT];
        if (wp_n_s || wdata_reg[`FSO_ST1_LOCK]) begin
          lock_reg <= wdata_reg[`FSO_ST1_LOCK];
        end
      end
      if (stat2_wr_end && wr_commit) begin
        rst_en_reg <= wdata_reg[`FSO_ST2_RST_EN];
      end
      if (op_end && !op_aborted) begin
        fail_reg <= op_failed;
      end
      // clears need a whole opcode; the engine reports its own ends
      if (op_end || hold_abort || stat_wr_end || stat2_wr_end) begin
        wel_reg <= 1'b0;
      end
      if (cs_rise && opcode_full && is_wr_disable) begin
        wel_reg <= 1'b0;
      end
      // set placed last so it wins over a clear in the same cycle
      if (cs_rise && opcode_full && is_wr_enable &&
          bit_cnt_reg == `FSO_BIT_FIRST) begin
        wel_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // registered state outputs
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      array_protect_bit <= 1'b0;
      write_latch_bit   <= 1'b0;
      write_allowed     <= 1'b0;
      reset_cmd_enable  <= 1'b0;
      status_byte_one   <= `FSO_BYTE_RST;
    end else begin
      array_protect_bit <= protect_reg;
      write_latch_bit   <= wel_reg;
      write_allowed     <= wel_reg && !protect_reg;
      reset_cmd_enable  <= rst_en_reg;
      status_byte_one   <= stat_one_now;
    end
  end

endmodule // fso_status_otp

// [dv/fso_status_otp_monitor.sv]
// concurrent checks on the status and security register read block ports
`timescale 1ns/1ps

module fso_status_otp_monitor (
  // clock and reset
  input logic       clk,
  input logic       rst_n,
  // pins and engine
  input logic       cs_n,
  input logic       sck,
  input logic       wp_n,
  input logic       so,
  input logic       so_oe_n,
  input logic       op_busy,
  input logic       op_end,
  input logic       op_aborted,
  input logic       op_failed,
  input logic       hold_abort,
  // status
  input logic       array_protect_bit,
  input logic       write_latch_bit,
  input logic       write_allowed,
  input logic [7:0] status_byte_one
);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  reserved_bits_a: assert property (status_byte_one[6] == 1'b0 && status_byte_one[3] == 1'b0)
    else $error("reserved status bit set");
  busy_copy_a: assert property ($stable(op_busy) [*4] |-> status_byte_one[0] == op_busy)
    else $error("busy bit does not follow engine");
  pin_state_a: assert property ($stable(wp_n) [*5] |-> status_byte_one[4] == wp_n)
    else $error("protect pin bit wrong");
  status_copy_a: assert property (
    $stable({write_latch_bit, array_protect_bit}) [*2]
    |-> status_byte_one[2:1] == {array_protect_bit, write_latch_bit})
    else $error("status copy of latch or protect wrong");
  write_gate_a: assert property (
    $stable({write_latch_bit, array_protect_bit}) [*2]
    |-> write_allowed == (write_latch_bit && !array_protect_bit))
    else $error("write gate wrong");
  latch_clear_a: assert property (op_end || hold_abort |-> ##2 !write_latch_bit)
    else $error("latch not cleared by engine end");
  fail_set_a: assert property (op_end && op_failed && !op_aborted
    |-> ##[1:3] status_byte_one[5])
    else $error("fail flag not set");
  fail_abort_a: assert property (op_end && op_aborted && !status_byte_one[5]
    |=> !status_byte_one[5] [*3])
    else $error("fail flag set by abort");
  output_float_a: assert property (cs_n [*6] |-> so_oe_n)
    else $error("output driven while deselected");
  shift_edge_a: assert property (!so_oe_n && $changed(so) |-> !sck)
    else $error("output changed with clock high");

  cover property (!so_oe_n && !cs_n);
  cover property (op_end && op_aborted);
  cover property ($rose(array_protect_bit));
endmodule // fso_status_otp_monitor

bind fso_status_otp fso_status_otp_monitor mon (.clk(clk), .rst_n(rst_n), .cs_n(cs_n),
  .sck(sck), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n), .op_busy(op_busy), .op_end(op_end),
  .op_aborted(op_aborted), .op_failed(op_failed), .hold_abort(hold_abort),
  .array_protect_bit(array_protect_bit), .write_latch_bit(write_latch_bit),
  .write_allowed(write_allowed), .status_byte_one(status_byte_one));

// [dv/fso_host_model.sv]
// host serial controller model, mode 0, clock still between frames
`timescale 1ns/1ps

module fso_host_model (
  // clock
  input  wire clk,
  // serial pins
  input  wire so_pin,
  output reg  cs_n,
  output reg  sck,
  output reg  si
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // ------------------------------------------------------------
  // frame tasks
  // ------------------------------------------------------------
  task automatic half;
    repeat (10) @(negedge clk);
  endtask
  task automatic open_frame;
    @(negedge clk);
    cs_n = 1'b0;
    half();
  endtask
  task automatic close_frame;
    @(negedge clk);
    cs_n = 1'b1;
    si = ~si;
    half();
  endtask
  // n bits msb first; so taken just before each rise
  task automatic shift(input int n, input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si = tx[i];
      half();
      rx[i] = so_pin;
      sck = 1'b1;
      half();
      sck = 1'b0;
    end
  endtask
endmodule // fso_host_model

// [dv/fso_status_otp_test.sv]
// self-checking bench for the status and security register read block
`timescale 1ns/1ps

module fso_status_otp_test;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       wp_n = 1'b1;
  logic       op_busy = 1'b0;
  logic       op_end = 1'b0;
  logic       op_failed = 1'b0;
  logic       op_aborted = 1'b0;
  logic       hold_abort = 1'b0;
  logic [7:0] rx;
  logic [6:0] a;
  int         err_count = 0;
  int         n_checks = 0;
  wire        cs_n, sck, si, so, so_oe_n, array_protect_bit;
  wire        write_latch_bit, write_allowed, reset_cmd_enable;
  wire  [6:0] otp_addr;
  wire  [7:0] status_byte_one;
  wire  [7:0] otp_data = {otp_addr, 1'b0} ^ 8'hA5;
  wire        so_pin = so_oe_n ? ~so : so;

  always #4 clk = ~clk;

  fso_host_model host (.clk(clk), .so_pin(so_pin), .cs_n(cs_n), .sck(sck), .si(si));
  fso_status_otp dut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si),
    .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n), .otp_addr(otp_addr), .otp_data(otp_data),
    .op_busy(op_busy), .op_end(op_end), .op_failed(op_failed), .op_aborted(op_aborted),
    .hold_abort(hold_abort), .array_protect_bit(array_protect_bit),
    .write_latch_bit(write_latch_bit), .write_allowed(write_allowed),
    .reset_cmd_enable(reset_cmd_enable), .status_byte_one(status_byte_one));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (err_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic frame(input logic [7:0] op, input int n, input int wr, input logic [7:0] d);
    host.open_frame();
    host.shift(n, op, rx);
    if (wr != 0)
      host.shift(8, d, rx);
    host.close_frame();
  endtask
  task automatic eng(input logic f, input logic ab, input logic h);
    frame(8'h06, 8, 0, 8'h00);
    @(negedge clk);
    op_failed = f;
    op_aborted = ab;
    op_end = ~h;
    hold_abort = h;
    @(negedge clk);
    op_end = 1'b0;
    hold_abort = 1'b0;
    repeat (6) @(negedge clk);
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    stop_test();
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    check(status_byte_one, 8'h10);
    op_busy = 1'b1;
    repeat (6) @(negedge clk);
    host.open_frame();
    host.shift(8, 8'h05, rx);
    host.shift(8, 8'h00, rx);
    check(rx, 8'h11);
    fork
      begin
        repeat (100) @(negedge clk);
        op_busy = 1'b0;
      end
    join_none
    host.shift(8, 8'h00, rx);
    check(rx, 8'h01);
    host.shift(8, 8'h00, rx);
    check(rx, 8'h10);
    host.shift(3, 8'h00, rx);
    host.close_frame();
    check({7'h00, so_oe_n}, 8'h01);
    frame(8'h06, 8, 0, 8'h00);
    check(status_byte_one, 8'h12);
    frame(8'hFF, 8, 0, 8'h00);
    frame(8'h01, 3, 0, 8'h00);
    check({6'h00, reset_cmd_enable, write_allowed}, 8'h01);
    frame(8'h01, 8, 1, 8'hFF);
    check(status_byte_one, 8'h94);
    frame(8'h01, 8, 1, 8'h00);
    check(status_byte_one, 8'h94);
    wp_n = 1'b0;
    frame(8'h06, 8, 0, 8'h00);
    frame(8'h01, 8, 1, 8'h00);
    check(status_byte_one, 8'h84);
    wp_n = 1'b1;
    frame(8'h06, 8, 0, 8'h00);
    frame(8'h01, 8, 1, 8'h00);
    check(status_byte_one, 8'h10);
    frame(8'h06, 8, 0, 8'h00);
    frame(8'h31, 8, 1, 8'h10);
    check({6'h00, reset_cmd_enable, write_allowed}, 8'h02);
    frame(8'h06, 8, 0, 8'h00);
    frame(8'h04, 8, 0, 8'h00);
    check(status_byte_one, 8'h10);
    eng(1'b1, 1'b1, 1'b0);
    check(status_byte_one, 8'h10);
    eng(1'b1, 1'b0, 1'b0);
    check(status_byte_one, 8'h30);
    eng(1'b0, 1'b0, 1'b1);
    check(status_byte_one, 8'h30);
    eng(1'b0, 1'b0, 1'b0);
    check(status_byte_one, 8'h10);
    host.open_frame();
    host.shift(8, 8'h77, rx);
    host.shift(8, 8'h00, rx);
    host.shift(8, 8'h00, rx);
    host.shift(8, 8'h7E, rx);
    host.shift(8, 8'h00, rx);
    host.shift(8, 8'h00, rx);
    for (int i = 0; i < 3; i++) begin
      a = 7'h7E + i[6:0];
      host.shift(8, 8'h00, rx);
      check(rx, {a, 1'b0} ^ 8'hA5);
    end
    host.shift(5, 8'h00, rx);
    host.close_frame();
    check({7'h00, so_oe_n}, 8'h01);
    stop_test();
  end
endmodule // fso_status_otp_test
